// ==== logic/card_slot_power_sequencer.sv ====
// card slot power sequencer: mode selection, reset timing, axi4-lite registers
`timescale 1ns/100ps
module card_slot_power_sequencer
    import card_power_pkg::*;
#(
    parameter int unsigned RESET_DELAY = RESET_DELAY_CYC,
    parameter int unsigned OC_DELAY    = OC_DEGLITCH_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic        aux_input_good,
    input  wire logic        main_input_good,
    input  wire logic        low_input_good,
    input  wire logic        shutdown_n,
    input  wire logic        standby_n,
    input  wire logic        card_present_pcie_n,
    input  wire logic        card_present_usb_n,
    input  wire logic        host_reset_n,
    input  wire logic        rails_in_tolerance,
    input  wire logic [2:0]  switch_overcurrent,
    input  wire logic        refclk_enable_i,
    output logic             refclk_enable_o,
    output logic             refclk_enable_oe,
    output logic             overcurrent_n_o,
    output logic             overcurrent_n_oe,
    output logic             card_reset_n,
    output logic             aux_switch_en,
    output logic             main_switch_en,
    output logic             low_switch_en,
    output logic             discharge_en,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam logic [SYNC_W-1:0] SYNC_RST = '0;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] pins;
    logic              aux_ok;
    logic              main_ok;
    logic              low_ok;
    logic              shutdown_n_n;
    logic              standby_n_n;
    logic              card_n;
    logic              hrst_n;
    logic              rclk_pin;
    logic              rail_ok;
    logic              oc_any;
    logic              rclk_pin_d_r;
    logic              card_n_d_r;
    mode_t             mode_r;
    mode_t             mode_nxt;
    mode_t             saved_mode_r;
    logic              main_sw_nxt;
    logic              low_sw_nxt;
    logic              brk_done_r;
    logic              timer_run_r;
    logic [31:0]       timer_r;
    logic [31:0]       oc_cnt_r;
    logic              indep_r;
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [31:0]       awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;

    assign sync_in = {switch_overcurrent[2], switch_overcurrent[1], switch_overcurrent[0],
                      rails_in_tolerance, refclk_enable_i, host_reset_n,
                      card_present_usb_n, card_present_pcie_n, standby_n, shutdown_n,
                      low_input_good, main_input_good, aux_input_good};

    input_sync #(.W(SYNC_W)) u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (clk_en),
        .async_in  (sync_in),
        .reset_val (SYNC_RST),
        .sync_out  (pins)
    );

    assign aux_ok   = pins[IN_AUX];
    assign main_ok  = pins[IN_MAIN];
    assign low_ok   = pins[IN_LOW];
    assign shutdown_n_n   = pins[IN_SHUTDOWN_N];
    assign standby_n_n   = pins[IN_STANDBY_N];
    assign card_n   = pins[IN_CARD_PRESENT_PCIE_N] & pins[IN_CARD_PRESENT_USB_N];
    assign hrst_n   = pins[IN_HRST];
    assign rclk_pin = pins[IN_RCLK];
    assign rail_ok  = pins[IN_RAIL];
    assign oc_any   = |pins[SYNC_W-1:IN_OC];

    // mode selection; card insertion judged on card_n held low, for two cycles when leaving MODE_OFF
    always_comb begin
        mode_nxt = mode_r;
        if (!aux_ok) begin
            mode_nxt = MODE_OFF;
        end else if (!shutdown_n_n) begin
            mode_nxt = MODE_SHUTDOWN;
        end else if (card_n) begin
            // slot emptied during shutdown: never re-power it from the saved mode
            mode_nxt = MODE_NOCARD;
        end else if (mode_r == MODE_SHUTDOWN) begin
            mode_nxt = saved_mode_r;
        end else begin
            unique case (mode_r)
                MODE_NOCARD: begin
                    mode_nxt = (main_ok && low_ok && standby_n_n) ? MODE_INSERTED : MODE_OFF;
                end
                MODE_OFF: begin
                    if (card_n_d_r == 1'b0 && standby_n_n && (main_ok && low_ok || indep_r &&
                        (main_ok || low_ok))) begin
                        mode_nxt = MODE_INSERTED;
                    end
                end
                MODE_INSERTED: begin
                    if (!standby_n_n || (!indep_r && !(main_ok && low_ok))) begin
                        mode_nxt = MODE_STANDBY;
                    end
                end
                MODE_STANDBY: begin
                    if (standby_n_n && main_ok && low_ok) begin
                        mode_nxt = MODE_INSERTED;
                    end
                end
                default: mode_nxt = MODE_OFF;
            endcase
        end
    end

    // primary switches; variant lets each rail follow its own input only
    always_comb begin
        main_sw_nxt = (mode_nxt == MODE_INSERTED);
        low_sw_nxt  = (mode_nxt == MODE_INSERTED);
        if (indep_r && mode_nxt == MODE_INSERTED) begin
            main_sw_nxt = main_ok;
            low_sw_nxt  = low_ok;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r       <= MODE_OFF;
            saved_mode_r <= MODE_NOCARD;
            card_n_d_r   <= 1'b1;
        end else if (clk_en) begin
            mode_r     <= mode_nxt;
            card_n_d_r <= card_n;
            if (mode_r != MODE_SHUTDOWN && mode_nxt == MODE_SHUTDOWN) begin
                saved_mode_r <= (mode_r == MODE_OFF) ? MODE_NOCARD : mode_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_switch_en  <= 1'b0;
            main_switch_en <= 1'b0;
            low_switch_en  <= 1'b0;
        end else if (clk_en) begin
            aux_switch_en  <= (mode_nxt == MODE_INSERTED) || (mode_nxt == MODE_STANDBY);
            main_switch_en <= main_sw_nxt;
            low_switch_en  <= low_sw_nxt;
        end
    end

    // discharge waits a cycle with switches already off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_done_r   <= 1'b0;
            discharge_en <= 1'b0;
        end else if (clk_en) begin
            brk_done_r <= !(aux_switch_en || main_switch_en || low_switch_en);
            // shutdown keeps discharge regardless of card present
            discharge_en <= (mode_r == MODE_SHUTDOWN ||
                             (mode_r == MODE_NOCARD && card_n)) &&
                            brk_done_r && !(aux_switch_en || main_switch_en || low_switch_en);
        end
    end

    // refclk line: open drain, low while rails bad; host reset does not touch it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refclk_enable_oe <= 1'b1;
            refclk_enable_o  <= 1'b0;
            rclk_pin_d_r     <= 1'b0;
        end else if (clk_en) begin
            refclk_enable_o  <= 1'b0;
            refclk_enable_oe <= !(mode_r == MODE_INSERTED && rail_ok);
            rclk_pin_d_r     <= rclk_pin;
        end
    end

    // release timer: armed on refclk rising edge, dropped if mode, rails or refclk lost; host reset does not drop it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_run_r <= 1'b0;
            timer_r     <= '0;
        end else if (clk_en) begin
            if (mode_r != MODE_INSERTED || !rail_ok || !rclk_pin) begin
                timer_run_r <= 1'b0;
                timer_r     <= '0;
            end else if (rclk_pin && !rclk_pin_d_r) begin
                timer_run_r <= 1'b1;
                timer_r     <= '0;
            end else if (timer_run_r && timer_r < RESET_DELAY) begin
                timer_r <= timer_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_reset_n <= 1'b0;
        end else if (clk_en) begin
            card_reset_n <= timer_run_r && timer_r >= RESET_DELAY && rail_ok && hrst_n &&
                            rclk_pin && mode_r == MODE_INSERTED;
        end
    end

    // overcurrent deglitch: must persist OC_DELAY cycles before flagging
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc_cnt_r         <= '0;
            overcurrent_n_oe <= 1'b0;
            overcurrent_n_o  <= 1'b0;
        end else if (clk_en) begin
            overcurrent_n_o <= 1'b0;
            if (!oc_any) begin
                oc_cnt_r         <= '0;
                overcurrent_n_oe <= 1'b0;
            end else if (oc_cnt_r < OC_DELAY) begin
                oc_cnt_r <= oc_cnt_r + 32'h0000_0001;
            end else begin
                overcurrent_n_oe <= 1'b1;
            end
        end
    end

    // axi4-lite write: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            indep_r       <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r     <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_r[7:0] == CTRL_OFFSET[7:0] && awaddr_r[31:8] == '0) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (wstrb_r[0]) begin
                        indep_r <= wdata_r[CTRL_INDEP_BIT];
                    end
                end else if (awaddr_r == STATUS_OFFSET || awaddr_r == INPUTS_OFFSET) begin
                    s_axi_bresp <= RESP_OKAY; // read-only, write ignored
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                if (s_axi_araddr == CTRL_OFFSET) begin
                    s_axi_rdata <= {31'h0000_0000, indep_r};
                end else if (s_axi_araddr == STATUS_OFFSET) begin
                    s_axi_rdata <= {20'h0_0000, card_reset_n, refclk_enable_oe,
                                    overcurrent_n_oe, discharge_en, low_switch_en,
                                    main_switch_en, aux_switch_en, 5'(mode_r)};
                end else if (s_axi_araddr == INPUTS_OFFSET) begin
                    s_axi_rdata <= {19'h0_0000, pins};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== logic/card_power_pkg.sv ====
// constants, register map and mode encoding for the card slot power sequencer
package card_power_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned RESET_DELAY_US   = 100;
    localparam int unsigned RESET_DELAY_CYC  = RESET_DELAY_US * CLK_MHZ;
    localparam int unsigned OC_DEGLITCH_NS   = 1000;
    localparam int unsigned OC_DEGLITCH_CYC  = (OC_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SYNC_W           = 13;

    localparam logic [31:0] CTRL_OFFSET      = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET    = 32'h0000_0004;
    localparam logic [31:0] INPUTS_OFFSET    = 32'h0000_0008;
    localparam int unsigned CTRL_INDEP_BIT   = 0;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // input vector bit positions after synchronising
    localparam int unsigned IN_AUX   = 0;
    localparam int unsigned IN_MAIN  = 1;
    localparam int unsigned IN_LOW   = 2;
    localparam int unsigned IN_SHUTDOWN_N  = 3;
    localparam int unsigned IN_STANDBY_N  = 4;
    localparam int unsigned IN_CARD_PRESENT_PCIE_N  = 5;
    localparam int unsigned IN_CARD_PRESENT_USB_N = 6;
    localparam int unsigned IN_HRST  = 7;
    localparam int unsigned IN_RCLK  = 8;
    localparam int unsigned IN_RAIL  = 9;
    localparam int unsigned IN_OC    = 10;

    typedef enum logic [4:0] {
        MODE_OFF      = 5'h01,
        MODE_SHUTDOWN = 5'h02,
        MODE_NOCARD   = 5'h04,
        MODE_STANDBY  = 5'h08,
        MODE_INSERTED = 5'h10
    } mode_t;
endpackage

// ==== logic/input_sync.sv ====
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module input_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] reset_val,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // reset value is a constant at the instance, never a live pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r   <= reset_val;
            sync_out <= reset_val;
        end else if (ce) begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ==== testbench/card_power_assertions.sv ====
// port-level assertion checker for the card slot power sequencer
`timescale 1ns/100ps
module card_power_assertions #(
    parameter int unsigned RESET_DELAY = 20,
    parameter int unsigned OC_DELAY    = 16
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       aux_input_good,
    input wire logic       shutdown_n,
    input wire logic       card_present_pcie_n,
    input wire logic       card_present_usb_n,
    input wire logic       host_reset_n,
    input wire logic       rails_in_tolerance,
    input wire logic [2:0] switch_overcurrent,
    input wire logic       refclk_enable_i,
    input wire logic       refclk_enable_o,
    input wire logic       refclk_enable_oe,
    input wire logic       overcurrent_n_o,
    input wire logic       overcurrent_n_oe,
    input wire logic       card_reset_n,
    input wire logic       aux_switch_en,
    input wire logic       main_switch_en,
    input wire logic       low_switch_en,
    input wire logic       discharge_en
);
    logic [15:0] wait_cnt_r;
    logic [15:0] ovc_cnt_r;
    logic        any_sw_r;
    logic        any_sw;
    assign any_sw = aux_switch_en || main_switch_en || low_switch_en;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // run lengths saturate so a long steady state never wraps back to zero
    always_ff @(posedge aclk) begin
        if (!aresetn || !(refclk_enable_i && rails_in_tolerance)) wait_cnt_r <= 16'h0000;
        else if (wait_cnt_r != 16'hFFFF) wait_cnt_r <= wait_cnt_r + 16'h0001;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !(|switch_overcurrent)) ovc_cnt_r <= 16'h0000;
        else if (ovc_cnt_r != 16'hFFFF) ovc_cnt_r <= ovc_cnt_r + 16'h0001;
    end
    always_ff @(posedge aclk) begin
        any_sw_r <= aresetn ? any_sw : 1'b0;
    end
    a_aux_off_all: assert property (
        !aux_input_good [*5] |-> !any_sw && !discharge_en)
        else $error("switch or discharge on without aux input");
    a_shutdown_safe: assert property (
        (aux_input_good && !shutdown_n) [*6]
        |-> !any_sw && discharge_en && !card_reset_n && refclk_enable_oe)
        else $error("shutdown outputs wrong");
    a_no_card: assert property (
        (aux_input_good && shutdown_n && card_present_pcie_n && card_present_usb_n) [*6]
        |-> !any_sw && discharge_en && !card_reset_n && refclk_enable_oe)
        else $error("empty slot outputs wrong");
    a_host_reset: assert property (
        !host_reset_n [*5] |-> !card_reset_n)
        else $error("card reset high during host reset");
    a_rail_drop: assert property (
        !rails_in_tolerance [*5] |-> !card_reset_n && refclk_enable_oe)
        else $error("rails out of tolerance but reset or refclk released");
    a_release_wait: assert property (
        $rose(card_reset_n) |-> wait_cnt_r >= RESET_DELAY)
        else $error("card reset released before delay ran out");
    a_ovc_deglitch: assert property (
        $rose(overcurrent_n_oe) |-> ovc_cnt_r >= OC_DELAY)
        else $error("overcurrent flagged before deglitch time");
    a_ovc_clear: assert property (
        !(|switch_overcurrent) [*5] |-> !overcurrent_n_oe)
        else $error("overcurrent flag stuck");
    a_open_drain: assert property (
        refclk_enable_o == 1'b0 && overcurrent_n_o == 1'b0)
        else $error("open-drain output driven high");
    a_break_make: assert property (
        $rose(discharge_en) |-> !any_sw_r && !any_sw)
        else $error("discharge on while a switch conducts");
endmodule

bind card_slot_power_sequencer card_power_assertions #(
    .RESET_DELAY(RESET_DELAY), .OC_DELAY(OC_DELAY)) checker_i (
    .aclk(aclk), .aresetn(aresetn), .aux_input_good(aux_input_good),
    .shutdown_n(shutdown_n), .card_present_pcie_n(card_present_pcie_n),
    .card_present_usb_n(card_present_usb_n), .host_reset_n(host_reset_n),
    .rails_in_tolerance(rails_in_tolerance), .switch_overcurrent(switch_overcurrent),
    .refclk_enable_i(refclk_enable_i), .refclk_enable_o(refclk_enable_o),
    .refclk_enable_oe(refclk_enable_oe), .overcurrent_n_o(overcurrent_n_o),
    .overcurrent_n_oe(overcurrent_n_oe), .card_reset_n(card_reset_n),
    .aux_switch_en(aux_switch_en), .main_switch_en(main_switch_en),
    .low_switch_en(low_switch_en), .discharge_en(discharge_en));

// ==== testbench/slot_partner.sv ====
// far-side model: plug-in card, its output rails and the host hold on refclk
`timescale 1ns/100ps
module slot_partner (
    input  wire logic aclk,
    input  wire logic insert_pcie,
    input  wire logic insert_usb,
    input  wire logic hold_refclk,
    input  wire logic rail_fault,
    input  wire logic slow,
    input  wire logic aux_switch_en,
    input  wire logic main_switch_en,
    input  wire logic low_switch_en,
    input  wire logic refclk_enable_oe,
    output logic      card_present_pcie_n,
    output logic      card_present_usb_n,
    output logic      rails_in_tolerance,
    output logic      refclk_enable_i
);
    logic [4:0] ramp_r;
    // card grounds the lines it supports, pull-up otherwise
    assign card_present_pcie_n = !insert_pcie;
    assign card_present_usb_n = !insert_usb;
    // rails settle after a ramp; slow mode stretches it
    always_ff @(posedge aclk) begin
        if (!(aux_switch_en && main_switch_en && low_switch_en)) ramp_r <= 5'h00;
        else if (ramp_r != 5'h1F) ramp_r <= ramp_r + 5'h01;
    end
    assign rails_in_tolerance = !rail_fault && (ramp_r >= (slow ? 5'h1C : 5'h02));
    // host only pulls low, pull-up lifts the released line
    assign refclk_enable_i = !(refclk_enable_oe || hold_refclk);
endmodule

// ==== testbench/card_slot_power_sequencer_tb.sv ====
// self-checking bench for the card slot power sequencer
`timescale 1ns/100ps
module card_slot_power_sequencer_tb;
    import card_power_pkg::*;
    localparam int unsigned RD = 20;
    localparam int unsigned OD = 16;
    logic        aclk = 1'b0, aresetn = 1'b0, aux_ok = 1'b0, main_ok = 1'b0, low_ok = 1'b0;
    logic        shut_n = 1'b1, stand_n = 1'b1, host_rst_n = 1'b1, ins_pcie = 1'b0;
    logic        ins_usb = 1'b0, hold_clk = 1'b0, fault = 1'b0, slow = 1'b0, indep = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [2:0]  ovc = 3'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d, v;
    logic [1:0]  r, bresp, rresp;
    logic [31:0] rdata;
    logic        ref_o, ref_oe, ovc_o, ovc_oe, card_rst_n, sw_aux, sw_main, sw_low, dis;
    logic        rails, ref_i, pcie_n, usb_n, awready, wready, bvalid, arready, rvalid;
    int          fails = 0, total_checks = 0, m = 0, saved = 2;
    card_slot_power_sequencer #(.RESET_DELAY(RD), .OC_DELAY(OD)) uut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .aux_input_good(aux_ok),
        .main_input_good(main_ok), .low_input_good(low_ok), .shutdown_n(shut_n),
        .standby_n(stand_n), .card_present_pcie_n(pcie_n), .card_present_usb_n(usb_n),
        .host_reset_n(host_rst_n), .rails_in_tolerance(rails), .switch_overcurrent(ovc),
        .refclk_enable_i(ref_i), .refclk_enable_o(ref_o), .refclk_enable_oe(ref_oe),
        .overcurrent_n_o(ovc_o), .overcurrent_n_oe(ovc_oe), .card_reset_n(card_rst_n),
        .aux_switch_en(sw_aux), .main_switch_en(sw_main), .low_switch_en(sw_low),
        .discharge_en(dis), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    slot_partner far (.aclk(aclk), .insert_pcie(ins_pcie), .insert_usb(ins_usb),
        .hold_refclk(hold_clk), .rail_fault(fault), .slow(slow), .aux_switch_en(sw_aux),
        .main_switch_en(sw_main), .low_switch_en(sw_low), .refclk_enable_oe(ref_oe),
        .card_present_pcie_n(pcie_n), .card_present_usb_n(usb_n),
        .rails_in_tolerance(rails), .refclk_enable_i(ref_i));
    initial forever #2 aclk = ~aclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // each channel released at the edge that takes it; ready held until answer
    task automatic axw(input logic [31:0] a, input logic [31:0] wd, output logic [1:0] rs);
        awaddr <= a;
        wdata <= wd;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] rd, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // settle, step the mode model, compare outputs and the status register
    task automatic apply();
        logic [31:0] st;
        logic [1:0]  rs;
        logic [3:0]  ex;
        repeat (10) @(posedge aclk);
        if (!aux_ok) m = 0;
        else if (!shut_n) begin
            if (m != 1) saved = (m == 0) ? 2 : m;
            m = 1;
        end else begin
            if (m == 1) m = saved;
            if (!ins_pcie && !ins_usb) m = 2;
            else if (m == 2 || m == 0) m = (main_ok && low_ok && stand_n) ? 4 : 0;
            else if (m == 4 && !(stand_n && (indep || main_ok && low_ok))) m = 3;
        end
        ex = {m > 2, m == 4 && (!indep || main_ok), m == 4 && (!indep || low_ok), m < 3 && m > 0};
        chk({sw_aux, sw_main, sw_low, dis}, ex);
        axr(STATUS_OFFSET, st, rs);
        chk(st[4:0], 5'h01 << m);
        if (m != 4) chk({card_rst_n, ref_oe}, 2'h1);
    endtask
    task automatic rst_after(input int lo, input int hi);
        int n;
        for (n = 0; n < hi && card_rst_n !== 1'b1; n++) @(posedge aclk);
        chk(n >= lo && card_rst_n === 1'b1, 1'b1);
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        v = $urandom(32'h1504);
        axr(CTRL_OFFSET, d, r);
        chk(d[0], 1'b0);
        axw(CTRL_OFFSET, v, r);
        axr(CTRL_OFFSET, d, r);
        chk({r, d[0]}, {RESP_OKAY, v[0]});
        axw(STATUS_OFFSET, 32'hFFFF_FFFF, r);
        chk(r, RESP_OKAY);
        axr(32'h0000_0010, d, r);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        axw(32'h0000_0010, 32'h1, r);
        chk(r, RESP_SLVERR);
        @(posedge aclk);
        axw(CTRL_OFFSET, 32'h0, r);
        $display("registers done");
        aux_ok <= 1'b1;
        main_ok <= 1'b1;
        low_ok <= 1'b1;
        apply();
        hold_clk <= 1'b1;
        ins_pcie <= 1'b1;
        apply();
        repeat (40) @(posedge aclk);
        chk(card_rst_n, 1'b0);
        hold_clk <= 1'b0;
        repeat (RD / 2) @(posedge aclk);
        hold_clk <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(card_rst_n, 1'b0);
        hold_clk <= 1'b0;
        rst_after(RD, RD + 8);
        host_rst_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({card_rst_n, sw_aux, sw_main, sw_low, ref_oe}, 5'h0E);
        host_rst_n <= 1'b1;
        rst_after(1, RD + 10);
        fault <= 1'b1;
        repeat (6) @(posedge aclk);
        chk({card_rst_n, ref_oe}, 2'h1);
        fault <= 1'b0;
        slow <= 1'b1;
        rst_after(RD, RD + 10);
        $display("power-up and reset done");
        stand_n <= 1'b0;
        apply();
        shut_n <= 1'b0;
        apply();
        shut_n <= 1'b1;
        apply();
        ins_pcie <= 1'b0;
        apply();
        stand_n <= 1'b1;
        main_ok <= 1'b0;
        apply();
        ins_usb <= 1'b1;
        apply();
        main_ok <= 1'b1;
        apply();
        low_ok <= 1'b0;
        apply();
        ins_usb <= 1'b0;
        apply();
        low_ok <= 1'b1;
        apply();
        $display("mode sequence done");
        axw(CTRL_OFFSET, 32'h1, r);
        indep = 1'b1;
        ins_pcie <= 1'b1;
        ins_usb <= 1'b1;
        apply();
        main_ok <= 1'b0;
        apply();
        main_ok <= 1'b1;
        apply();
        axw(CTRL_OFFSET, 32'h0, r);
        indep = 1'b0;
        $display("independent rails done");
        ovc <= 3'h1 << (v[9:8] % 2'd3);
        repeat (1 + v[3:0] % 4'd12) @(posedge aclk);
        ovc <= 3'h0;
        repeat (6) @(posedge aclk);
        chk(ovc_oe, 1'b0);
        ovc <= 3'h1 << (v[9:8] % 2'd3);
        repeat (OD + 6) @(posedge aclk);
        chk({ovc_oe, ovc_o}, 2'h2);
        ovc <= 3'h0;
        repeat (6) @(posedge aclk);
        chk(ovc_oe, 1'b0);
        $display("overcurrent done");
        aux_ok <= 1'b0;
        apply();
        $display("aux loss done");
        conclude();
    end
endmodule
